// ---- dec_defs.svh ----
`ifndef DEC_DEFS_SVH
`define DEC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL         8'h00
`define REG_PAGE         8'h04
`define REG_ACC          8'h08
`define REG_STATUS       8'h0C
`define REG_INDEX        8'h10
`define REG_INSTR        8'h14
`define REG_MADDR        8'h18
`define REG_MDATA        8'h1C
`define REG_ESTAT        8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_EXT_BIT     0
`define ESTAT_BUSY_BIT   0
`define ESTAT_DONE_BIT   1
`define ESTAT_BADOP_BIT  2
`define OPC_HI           15
`define OPC_LO           10
`define DEST_BIT         9
`define BANKSEL_BIT      8

// ----------------------------------------------------------------
// Codes, reset values and address constants
// ----------------------------------------------------------------
`define OPC_MINUS_ONE    6'h01
`define ACCESS_SPLIT     8'h60
`define ILO_MAX          8'h5F
`define LOW_BANK         4'h0
`define HIGH_BANK        4'hF
`define CTRL_RST         1'h0
`define PAGE_RST         4'h0
`define ACC_RST          8'h00
`define STATUS_RST       5'h00
`define INDEX_RST        12'h000
`define INSTR_RST        16'h0000
`define MADDR_RST        12'h000
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- dec_pkg.sv ----
package dec_pkg;

  // ----------------------------------------------------------------
  // Execution phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_READ,
    ST_PROC,
    ST_WRITE
  } state_t;

  // Decoded operand fields
  typedef struct packed {
    logic       dest;
    logic       bank_sel;
    logic [7:0] addr;
  } op_fields_t;

  // Status flags, C in bit 0
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_t;

endpackage : dec_pkg

// ---- dec_alu.sv ----
`timescale 1ns/1ps
`include "dec_defs.svh"

module dec_alu (
  input  wire logic [7:0]     i_operand,
  output logic [7:0]          o_result,
  output dec_pkg::flags_t     o_flags
);

  // ----------------------------------------------------------------
  // Subtract one and derive flags
  // ----------------------------------------------------------------
  // Carry and digit carry mean "no borrow", as for any subtraction
  assign o_result   = i_operand - 8'h01;
  assign o_flags.c  = (i_operand != 8'h00);
  assign o_flags.dc = (i_operand[3:0] != 4'h0);
  assign o_flags.z  = (o_result == 8'h00);
  assign o_flags.n  = o_result[7];
  assign o_flags.ov = (i_operand == 8'h80);              // Only -128 overflows

endmodule : dec_alu

// ---- data_ram.sv ----
`timescale 1ns/1ps

module data_ram (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_we,
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata
);

  logic [7:0] mem_reg [0:4095];

  // ----------------------------------------------------------------
  // Single port, registered read, write-first
  // ----------------------------------------------------------------
  // Write-first keeps a following read coherent without a bypass
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_reg[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_we ? i_wdata : mem_reg[i_addr];
    end
  end

endmodule : data_ram

// ---- decrement_file_register_exec.sv ----
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dec_defs.svh"

module decrement_file_register_exec (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_busy
);

  dec_pkg::state_t     state_reg, state_next;
  dec_pkg::op_fields_t op_reg, instr_fields;
  dec_pkg::flags_t     status_reg, flags_reg, alu_flags;
  logic        aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic        ctrl_ext_reg, done_reg, badop_reg, ilo_reg;
  logic [3:0]  ram_page_register_reg;
  logic [7:0]  w_reg, result_reg, alu_result, ram_rdata, ram_wdata;
  logic [11:0] index_reg, maddr_reg, ea_reg, ram_addr;
  logic [15:0] instr_reg;
  logic [31:0] wmask, wnew;
  logic        busy, do_write, do_read, wr_ok, wr_mapped, rd_mapped, opc_ok;
  logic        ilo_mode, ram_we, core_we, sw_we, start;
  logic [11:0] access_ea, banked_ea, index_ea, ea_next;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Bus slave handshakes
  // ----------------------------------------------------------------
  // Address and data are parked independently, so either may come first
  assign o_awready = !aw_hold_reg;
  assign o_wready  = !w_hold_reg;
  assign o_arready = !rvalid_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rresp   = rresp_reg;
  assign o_rdata   = rdata_reg;
  assign do_write  = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign do_read   = i_arvalid && !rvalid_reg;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (i_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= i_awaddr;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (i_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= i_wdata;
        wstrb_reg  <= i_wstrb;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RESP_OKAY;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Byte strobes form a bit mask; unstrobed lanes keep their old bits
  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign wmask[8*i +: 8] = {8{wstrb_reg[i]}};
  end

  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [31:0] mask);
    merge = (old_val & ~mask) | (new_val & mask);
  endfunction : merge

  assign busy      = (state_reg != dec_pkg::ST_IDLE);
  assign wr_ok     = do_write && !busy;   // Writes during an instruction are dropped
  assign wr_mapped = (awaddr_reg <= `REG_ESTAT) && (awaddr_reg[1:0] == 2'h0);
  assign rd_mapped = (i_araddr <= `REG_ESTAT) && (i_araddr[1:0] == 2'h0);
  assign sw_we     = wr_ok && (awaddr_reg == `REG_MDATA) && wstrb_reg[0];
  assign start     = wr_ok && (awaddr_reg == `REG_INSTR);
  assign wnew      = merge(32'h0000_0000, wdata_reg, wmask);

  assign rd_word =
    (i_araddr == `REG_CTRL)   ? {31'h0, ctrl_ext_reg} :
    (i_araddr == `REG_PAGE)   ? {28'h0, ram_page_register_reg} :
    (i_araddr == `REG_ACC)    ? {24'h0, w_reg} :
    (i_araddr == `REG_STATUS) ? {27'h0, status_reg} :
    (i_araddr == `REG_INDEX)  ? {20'h0, index_reg} :
    (i_araddr == `REG_INSTR)  ? {16'h0, instr_reg} :
    (i_araddr == `REG_MADDR)  ? {20'h0, maddr_reg} :
    (i_araddr == `REG_MDATA)  ? {24'h0, ram_rdata} :
    (i_araddr == `REG_ESTAT)  ? {29'h0, badop_reg, done_reg, busy} :
                                32'h0000_0000;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl_ext_reg          <= `CTRL_RST;
      ram_page_register_reg <= `PAGE_RST;
      index_reg             <= `INDEX_RST;
      instr_reg             <= `INSTR_RST;
      maddr_reg             <= `MADDR_RST;
    end else if (wr_ok) begin
      if (awaddr_reg == `REG_CTRL && wstrb_reg[0]) begin
        ctrl_ext_reg <= wdata_reg[`CTRL_EXT_BIT];
      end
      if (awaddr_reg == `REG_PAGE && wstrb_reg[0]) begin
        ram_page_register_reg <= wdata_reg[3:0];
      end
      if (awaddr_reg == `REG_INDEX) begin
        index_reg <= (index_reg & ~wmask[11:0]) | (wdata_reg[11:0] & wmask[11:0]);
      end
      if (awaddr_reg == `REG_INSTR) begin
        instr_reg <= (instr_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
      end
      if (awaddr_reg == `REG_MADDR) begin
        maddr_reg <= (maddr_reg & ~wmask[11:0]) | (wdata_reg[11:0] & wmask[11:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Operand decode and effective address
  // ----------------------------------------------------------------
  assign instr_fields = {instr_reg[`DEST_BIT], instr_reg[`BANKSEL_BIT], instr_reg[7:0]};
  assign opc_ok    = (instr_reg[`OPC_HI:`OPC_LO] == `OPC_MINUS_ONE);
  assign ilo_mode  = ctrl_ext_reg && !instr_fields.bank_sel
                     && (instr_fields.addr <= `ILO_MAX);
  assign access_ea = (instr_fields.addr < `ACCESS_SPLIT)
                     ? {`LOW_BANK, instr_fields.addr}
                     : {`HIGH_BANK, instr_fields.addr};
  assign banked_ea = {ram_page_register_reg, instr_fields.addr};
  assign index_ea  = index_reg + {4'h0, instr_fields.addr};
  assign ea_next   = instr_fields.bank_sel ? banked_ea :
                     ilo_mode              ? index_ea  : access_ea;

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // Bad opcodes abort in decode so nothing is read or written
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dec_pkg::ST_IDLE:   state_next = start ? dec_pkg::ST_DECODE : dec_pkg::ST_IDLE;
      dec_pkg::ST_DECODE: state_next = opc_ok ? dec_pkg::ST_READ : dec_pkg::ST_IDLE;
      dec_pkg::ST_READ:   state_next = dec_pkg::ST_PROC;
      dec_pkg::ST_PROC:   state_next = dec_pkg::ST_WRITE;
      dec_pkg::ST_WRITE:  state_next = dec_pkg::ST_IDLE;
      default:            state_next = dec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= dec_pkg::ST_IDLE;
      op_reg    <= '0;
      ea_reg    <= 12'h000;
      ilo_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == dec_pkg::ST_DECODE) begin
        op_reg  <= instr_fields;
        ea_reg  <= ea_next;
        ilo_reg <= ilo_mode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data memory port and arithmetic
  // ----------------------------------------------------------------
  // While idle the port follows the software address window
  assign core_we   = (state_reg == dec_pkg::ST_WRITE) && op_reg.dest;
  assign ram_we    = core_we || sw_we;
  assign ram_addr  = busy ? ea_reg : maddr_reg;
  assign ram_wdata = core_we ? result_reg : wdata_reg[7:0];

  data_ram u_ram (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_we    (ram_we),
    .i_addr  (ram_addr),
    .i_wdata (ram_wdata),
    .o_rdata (ram_rdata)
  );

  dec_alu u_alu (
    .i_operand (ram_rdata),
    .o_result  (alu_result),
    .o_flags   (alu_flags)
  );

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      result_reg <= 8'h00;
      flags_reg  <= '0;
    end else if (state_reg == dec_pkg::ST_PROC) begin
      result_reg <= alu_result;
      flags_reg  <= alu_flags;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, flags and completion state
  // ----------------------------------------------------------------
  // Hardware updates win over software, which is idle-only anyway
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      w_reg      <= `ACC_RST;
      status_reg <= `STATUS_RST;
      done_reg   <= 1'b0;
      badop_reg  <= 1'b0;
    end else begin
      if (state_reg == dec_pkg::ST_WRITE) begin
        status_reg <= flags_reg;
        if (!op_reg.dest) begin
          w_reg <= result_reg;
        end
      end else if (wr_ok && awaddr_reg == `REG_ACC && wstrb_reg[0]) begin
        w_reg <= wdata_reg[7:0];
      end else if (wr_ok && awaddr_reg == `REG_STATUS && wstrb_reg[0]) begin
        status_reg <= wdata_reg[4:0];
      end
      if (state_reg == dec_pkg::ST_WRITE) begin
        done_reg <= 1'b1;
      end else if (start || (wr_ok && awaddr_reg == `REG_ESTAT
                             && wnew[`ESTAT_DONE_BIT])) begin
        done_reg <= 1'b0;
      end
      if (state_reg == dec_pkg::ST_DECODE) begin
        badop_reg <= !opc_ok;
      end
    end
  end

  assign o_busy = busy;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DEST_W: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_WRITE && !op_reg.dest)
      |-> !ram_we ##1 (w_reg == $past(result_reg)))
    else $error("Accumulator not loaded or memory written for dest 0");
  AST_DEST_F: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_WRITE && op_reg.dest)
      |-> (ram_we && ram_addr == ea_reg && ram_wdata == result_reg) ##1 $stable(w_reg))
    else $error("Write-back to memory missing for dest 1");
  AST_ACCESS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_READ && !op_reg.bank_sel && !ilo_reg)
      |-> ram_addr == ((op_reg.addr < `ACCESS_SPLIT) ? {`LOW_BANK, op_reg.addr}
                                                      : {`HIGH_BANK, op_reg.addr}))
    else $error("Quick-access address resolved wrongly");
  AST_BANKED: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_READ && op_reg.bank_sel)
      |-> (ram_addr == {ram_page_register_reg, op_reg.addr}) && !ilo_reg)
    else $error("Banked address does not use page register");
  AST_INDEXED: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_READ && ilo_reg)
      |-> ram_addr == index_reg + {4'h0, op_reg.addr})
    else $error("Indexed offset address wrong");
  AST_ILO_COND: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_DECODE && ctrl_ext_reg && !instr_fields.bank_sel
     && instr_fields.addr <= `ILO_MAX) |=> ilo_reg)
    else $error("Indexed mode not entered");
  AST_ARITH: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_PROC)
      |=> (result_reg == $past(ram_rdata) - 8'h01) && flags_reg.z == (result_reg == 8'h00)
          && flags_reg.c == ($past(ram_rdata) != 8'h00) && flags_reg.n == result_reg[7])
    else $error("Decrement result or flags wrong");
  AST_FLAGS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_WRITE) |=> status_reg == $past(flags_reg))
    else $error("Status not updated at write phase");
  AST_PHASES: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == dec_pkg::ST_DECODE && opc_ok) |=> state_reg == dec_pkg::ST_READ
      ##1 state_reg == dec_pkg::ST_PROC ##1 state_reg == dec_pkg::ST_WRITE
      ##1 state_reg == dec_pkg::ST_IDLE)
    else $error("Instruction phases out of order");

  COV_DEST_W: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == dec_pkg::ST_WRITE && !op_reg.dest);
  COV_DEST_F: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == dec_pkg::ST_WRITE && op_reg.dest && result_reg == 8'h00);
  COV_INDEXED: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == dec_pkg::ST_READ && ilo_reg);
  COV_BADOP: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == dec_pkg::ST_DECODE && !opc_ok);

endmodule : decrement_file_register_exec

// ---- decrement_file_register_exec_tb.sv ----
`timescale 1ns/1ps
`include "dec_defs.svh"

module decrement_file_register_exec_tb;

  // ----------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------
  logic        i_clk     = 1'b0;
  logic        i_nrst    = 1'b0;
  logic [7:0]  i_awaddr  = 8'h00;
  logic        i_awvalid = 1'b0;
  logic [31:0] i_wdata   = 32'h0;
  logic [3:0]  i_wstrb   = 4'hF;
  logic        i_wvalid  = 1'b0;
  logic        i_bready  = 1'b0;
  logic [7:0]  i_araddr  = 8'h00;
  logic        i_arvalid = 1'b0;
  logic        i_rready  = 1'b0;
  logic        o_awready;
  logic        o_wready;
  logic [1:0]  o_bresp;
  logic        o_bvalid;
  logic        o_arready;
  logic [31:0] o_rdata;
  logic [1:0]  o_rresp;
  logic        o_rvalid;
  logic        o_busy;
  int          error_cnt   = 0;
  int          check_count = 0;
  logic [31:0] seed        = 32'h501007D1;
  // Reset addresses and hand-picked corner operands
  logic [7:0]  rst_addr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
  logic [7:0]  cf [6]       = '{8'h5F, 8'h60, 8'h5F, 8'h60, 8'h00, 8'hFF};
  logic [7:0]  cop [6]      = '{8'h00, 8'h01, 8'h80, 8'h10, 8'hFF, 8'h7F};

  always #25 i_clk = ~i_clk;

  decrement_file_register_exec i_decrement_file_register_exec (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_busy(o_busy)
  );

  // ----------------------------------------
  // Reference functions and checks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Flags packed as {N,OV,Z,DC,C}
  function automatic logic [4:0] flg(input logic [7:0] op);
    logic [7:0] res;
    res = op - 8'h01;
    return {res[7], op == 8'h80, res == 8'h00, op[3:0] != 4'h0, op != 8'h00};
  endfunction : flg

  function automatic logic [11:0] eff(input logic a, input logic ext, input logic [7:0] f,
                                      input logic [3:0] pg, input logic [11:0] idx);
    if (a)
      return {pg, f};
    if (ext && f <= `ILO_MAX)
      return idx + {4'h0, f};
    return (f < `ACCESS_SPLIT) ? {`LOW_BANK, f} : {`HIGH_BANK, f};
  endfunction : eff

  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk_resp

  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  // Leading edge keeps two calls from driving one signal in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready === 1'b1)
        i_awvalid <= 1'b0;
      if (i_wvalid && o_wready === 1'b1)
        i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) begin
        r = o_bresp;
        i_bready <= 1'b0;
        return;
      end
    end
    error_cnt++;
    stop_test();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready === 1'b1)
        i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) begin
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        return;
      end
    end
    error_cnt++;
    stop_test();
  endtask : rd

  // One instruction with randomised page, index and accumulator
  task automatic run_op(input logic [5:0] opc, input logic d, input logic a,
                        input logic [7:0] f, input logic [7:0] op, input logic ext);
    logic [31:0] v;
    logic [1:0]  r;
    logic [11:0] ea;
    logic [7:0]  acc0;
    logic        good;
    int          n;
    v    = rnd();
    acc0 = v[7:0];
    ea   = eff(a, ext, f, v[11:8], v[23:12]);
    good = (opc == `OPC_MINUS_ONE);
    wr(`REG_CTRL, {31'h0, ext}, r);
    wr(`REG_PAGE, {28'h0, v[11:8]}, r);
    wr(`REG_INDEX, {20'h0, v[23:12]}, r);
    wr(`REG_ACC, {24'h0, acc0}, r);
    wr(`REG_MADDR, {20'h0, ea}, r);
    wr(`REG_MDATA, {24'h0, op}, r);
    wr(`REG_INSTR, {16'h0, opc, d, a, f}, r);
    chk_resp(r, `RESP_OKAY);
    for (n = 0; n < 20 && o_busy !== 1'b0; n++)
      @(posedge i_clk);
    if (n == 20) begin
      error_cnt++;
      stop_test();
    end
    rd(`REG_ACC, v, r);
    chk(v, {24'h0, (good && !d) ? op - 8'h01 : acc0});
    rd(`REG_MDATA, v, r);
    chk(v, {24'h0, (good && d) ? op - 8'h01 : op});
    rd(`REG_STATUS, v, r);
    if (good)
      chk(v, {27'h0, flg(op)});
    rd(`REG_ESTAT, v, r);
    chk(v, good ? 32'h2 : 32'h4);
  endtask : run_op

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    // Every register except MDATA reads zero out of reset
    for (int i = 0; i < 8; i++) begin
      rd(rst_addr[i], v, r);
      chk(v, 32'h0);
    end
    // Unmapped places answer with an error
    rd(8'h24, v, r);
    chk_resp(r, `RESP_SLVERR);
    wr(8'h02, 32'hFF, r);
    chk_resp(r, `RESP_SLVERR);
    // Lanes without strobe keep their old bits
    wr(`REG_INDEX, 32'h0000_0ABC, r);
    i_wstrb <= 4'h1;
    wr(`REG_INDEX, 32'h0000_0F55, r);
    i_wstrb <= 4'hF;
    rd(`REG_INDEX, v, r);
    chk(v, 32'h0000_0A55);
    // Boundary addresses around the indexed and quick-access splits
    for (int i = 0; i < 6; i++)
      run_op(`OPC_MINUS_ONE, i[0], 1'b0, cf[i], cop[i], i[1]);
    for (int i = 0; i < 40; i++) begin
      v = rnd();
      run_op(`OPC_MINUS_ONE, v[0], v[1], v[15:8], v[23:16], v[2]);
    end
    // Writing one to done clears it
    wr(`REG_ESTAT, 32'h0000_0002, r);
    rd(`REG_ESTAT, v, r);
    chk(v, 32'h0);
    // Wrong opcode leaves memory and accumulator alone
    run_op(6'h02, 1'b1, 1'b1, 8'h33, 8'h44, 1'b0);
    stop_test();
  end

endmodule : decrement_file_register_exec_tb
